// ---- verilog/bit_pkg.sv ----
// Purpose: shared constants and types for the baud and interval timer
// Assumes: the oscillator input is the system clock
// Notes: rate divisors count oscillator periods per 16x tick
package bit_pkg;
    localparam int CNT_W = 16;
    localparam int DIV_W = 13;
    localparam int IDX_W = 5;
    localparam int N_SEL = 4;
    localparam int BSRC_W = 2;
    localparam int MODE_TIMER_POS = 2;
    localparam int SRC_LO_POS = 0;
    localparam int SRC_W = 2;
    localparam logic [4:0] STD_RATES = 5'h1C;
    localparam logic [4:0] ALL_RATES = 5'h1F;
    localparam logic [15:0] CNT_WRAP = 16'hFF55;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic CT_OUT_RST = 1'h1;
    localparam logic READY_RST = 1'h0;
    localparam logic [3:0] CMD_TO_ON = 4'hA;
    localparam logic [3:0] CMD_TO_OFF = 4'hC;
    localparam logic [3:0] PRESCALE_TOP = 4'hF;

    typedef enum logic [1:0] {
        CT_SRC_EXT = 2'b00,
        CT_SRC_OSC = 2'b01,
        CT_SRC_OSC16 = 2'b10,
        CT_SRC_RSV = 2'b11
    } bit_ct_src_t;

    typedef enum logic [1:0] {
        BS_RATE = 2'b00,
        BS_CT = 2'b01,
        BS_EXT = 2'b10,
        BS_RSV = 2'b11
    } bit_baud_src_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_RESTART = 2'b10
    } bit_state_t;

    // 28 standard rates, then three extended ones
    localparam logic [12:0] RATE_DIV [0:30] = '{
        13'h1200, 13'h0C00, 13'h082F, 13'h06B1, 13'h0600, 13'h0480, 13'h039A,
        13'h0300, 13'h0200, 13'h01CD, 13'h0180, 13'h0100, 13'h00E6, 13'h00DB,
        13'h00C0, 13'h0080, 13'h0073, 13'h0060, 13'h004D, 13'h0040, 13'h0030,
        13'h0026, 13'h0020, 13'h0018, 13'h0010, 13'h000C, 13'h0008, 13'h0006,
        13'h0004, 13'h0002, 13'h0001
    };

    function automatic logic rate_ok(input logic [4:0] idx, input logic ext);
        rate_ok = (idx < STD_RATES) || (ext && (idx < ALL_RATES));
    endfunction
endpackage

// ---- verilog/bit_rate_if.sv ----
// Purpose: carries rate selections to the rate generator and its 16x ticks back
// Assumes: one selection field per clock selector
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface bit_rate_if;
    logic [bit_pkg::N_SEL*bit_pkg::IDX_W-1:0] rate_index;
    logic ext_rates;
    logic [bit_pkg::N_SEL-1:0] brg_tick;
    modport gen (input rate_index, input ext_rates, output brg_tick);
    modport user (output rate_index, output ext_rates, input brg_tick);
endinterface
`default_nettype wire

// ---- verilog/bit_rate_gen.sv ----
// Purpose: standard and extended 16x rate ticks, one divider per selector
// Assumes: clock is the oscillator input
// Notes: a faster oscillator scales every rate by the same ratio
`timescale 1ns/10ps
`default_nettype none
module bit_rate_gen (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    bit_rate_if.gen rif
);
    genvar g;
    generate
        for (g = 0; g < bit_pkg::N_SEL; g++) begin : g_sel
            logic [bit_pkg::DIV_W-1:0] cnt_r;
            logic tick_r;
            wire logic [bit_pkg::IDX_W-1:0] idx;
            wire logic ok;
            wire logic hit;
            wire logic [bit_pkg::DIV_W-1:0] reload;
            assign idx = rif.rate_index[g*bit_pkg::IDX_W +: bit_pkg::IDX_W];
            assign ok = bit_pkg::rate_ok(idx, rif.ext_rates); // [RULE14] [RULE15]
            assign hit = ok && (cnt_r == '0);
            // divisor is in oscillator periods: rates follow the input [RULE17]
            assign reload = ok ? bit_pkg::RATE_DIV[idx] - 13'h0001 : '0;
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    cnt_r <= '0;
                    tick_r <= 1'b0;
                end else if (clk_en) begin
                    // a shorter rate takes effect at once instead of draining the old count
                    cnt_r <= (hit || !ok || cnt_r > reload) ? reload : cnt_r - 13'h0001;
                    tick_r <= hit; // [RULE16]
                end
            end
            assign rif.brg_tick[g] = tick_r;

            a_ext_gate: assert property (@(posedge clock) disable iff (rst) // [RULE15]
                clk_en && !rif.ext_rates && idx >= bit_pkg::STD_RATES |=> !tick_r)
                else $error("extended rate ticked while disabled");
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verilog/bit_timer.sv ----
// Purpose: rate generator, four clock selectors and 16-bit counter/timer
// Assumes: all inputs synchronous to clock; commands are one-cycle pulses
// Notes: register values arrive as plain ports, no bus
// How it works
// RULE1: 16-bit divider runs as counter, timer or time-out using the divisor bytes.
// RULE2: mode select bits pick the divider clock source and counter or timer.
// RULE3: ready flag sets whenever the divider output falls from 1 to 0.
// RULE4: start and stop arrive as read strobes; no data involved.
// RULE5: start always copies the divisor bytes into the working count; the code ignores start in time-out mode.
// RULE6: stop always clears the ready flag; the code ignores stop in time-out mode, and a same-cycle set wins.
// RULE7: timer mode gives a square wave, half period equal to divisor ticks.
// RULE8: timer mode keeps running and setting ready despite stop.
// RULE9: count readback in timer mode carries no meaning.
// RULE10: divider as baud source means 16x sampling; software picks divisor.
// RULE11: counter mode counts to zero, then sets ready and drops output.
// RULE12: after zero, counter wraps to fixed value and counts on silently.
// RULE13: counter mode readback shows the live count.
// RULE14: rate generator offers 28 standard rates from the oscillator.
// RULE15: extended rate enable adds three more rates for both channels.
// RULE16: rate generator ticks at sixteen times the baud rate.
// RULE17: rates scale with the oscillator frequency.
// RULE18: four selectors choose rate generator, divider or external timing.
// RULE19: divider output is a baud source and can drive an output pin.
// RULE20: channel command 0xA enables time-out mode, 0xC disables it.
// RULE21: time-out: received character restarts divider next tick, clearing ready.
// RULE22: after reset divider idles, output high, ready clear.
`timescale 1ns/10ps
`default_nettype none
module bit_timer (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] divisor_low_byte,
    input wire logic [7:0] divisor_high_byte,
    input wire logic [2:0] ct_mode_sel,
    input wire logic ct_ext_clk,
    input wire logic start_cmd,
    input wire logic stop_cmd,
    input wire logic channel_a_cmd_wr,
    input wire logic [3:0] channel_a_cmd,
    input wire logic channel_b_cmd_wr,
    input wire logic [3:0] channel_b_cmd,
    input wire logic rx_fifo_load_a,
    input wire logic rx_fifo_load_b,
    input wire logic ext_rates_en,
    input wire logic [19:0] rate_index,
    input wire logic [7:0] baud_src,
    input wire logic [3:0] ext_timing,
    input wire logic ct_route_en,
    output logic [3:0] baud_tick,
    output logic ct_out,
    output logic ct_pin_out,
    output logic ready_flag,
    output logic [15:0] count_value,
    output logic timeout_mode
);
    bit_rate_if rif ();

    bit_pkg::bit_state_t state_r;
    bit_pkg::bit_state_t state_nxt;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic out_r;
    logic out_nxt;
    logic ready_r;
    logic to_en_r;
    logic ext_d_r;
    logic [3:0] pre_r;
    logic [3:0] ext_t_d_r;
    logic [3:0] tick_r;
    logic pin_r;
    logic ever_r;

    assign rif.rate_index = rate_index;
    assign rif.ext_rates = ext_rates_en;

    bit_rate_gen u_rate (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .rif(rif)
    );

    // mode decode; time-out forces counter behaviour
    wire logic [15:0] divisor = {divisor_high_byte, divisor_low_byte}; // [RULE1]
    wire logic timer_mode = ct_mode_sel[bit_pkg::MODE_TIMER_POS] && !to_en_r; // [RULE2]
    wire bit_pkg::bit_ct_src_t ct_src =
        bit_pkg::bit_ct_src_t'(ct_mode_sel[bit_pkg::SRC_LO_POS +: bit_pkg::SRC_W]);

    // divider clock enable from the chosen source
    wire logic ext_rise = ct_ext_clk && !ext_d_r;
    wire logic pre_hit = (pre_r == bit_pkg::PRESCALE_TOP);
    wire logic ct_tick = (ct_src == bit_pkg::CT_SRC_EXT) ? ext_rise :
                         (ct_src == bit_pkg::CT_SRC_OSC16) ? pre_hit : 1'b1; // [RULE2]

    // command decode
    wire logic to_on = (channel_a_cmd_wr && channel_a_cmd == bit_pkg::CMD_TO_ON) ||
                       (channel_b_cmd_wr && channel_b_cmd == bit_pkg::CMD_TO_ON);
    wire logic to_off = (channel_a_cmd_wr && channel_a_cmd == bit_pkg::CMD_TO_OFF) ||
                        (channel_b_cmd_wr && channel_b_cmd == bit_pkg::CMD_TO_OFF);
    // time-out mode swallows the plain start and stop strobes
    wire logic start_ok = start_cmd && !to_en_r; // [RULE4]
    wire logic stop_ok = stop_cmd && !to_en_r; // [RULE4]
    wire logic rx_load = (rx_fifo_load_a || rx_fifo_load_b) && to_en_r;
    wire logic restart_now = (state_r == bit_pkg::ST_RESTART) && ct_tick;
    wire logic at_one = (count_r == bit_pkg::CNT_ONE);
    wire logic at_zero = (count_r == bit_pkg::CNT_ZERO);

    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        out_nxt = out_r;
        unique case (state_r)
            bit_pkg::ST_IDLE: begin
                if (start_ok) begin
                    count_nxt = divisor; // [RULE5]
                    out_nxt = 1'b1;
                    state_nxt = bit_pkg::ST_RUN;
                end
            end
            bit_pkg::ST_RUN: begin
                if (start_ok) begin
                    count_nxt = divisor; // [RULE5]
                    out_nxt = 1'b1;
                end else if (stop_ok && !timer_mode) begin
                    state_nxt = bit_pkg::ST_IDLE; // [RULE8]
                end else if (ct_tick && timer_mode) begin
                    if (at_one) begin
                        count_nxt = divisor; // [RULE7]
                        out_nxt = !out_r;
                    end else begin
                        count_nxt = count_r - bit_pkg::CNT_ONE;
                    end
                end else if (ct_tick) begin
                    if (at_zero) begin
                        count_nxt = bit_pkg::CNT_WRAP; // [RULE12]
                    end else begin
                        count_nxt = count_r - bit_pkg::CNT_ONE;
                        if (at_one) begin
                            out_nxt = 1'b0; // [RULE11]
                        end
                    end
                end
            end
            bit_pkg::ST_RESTART: begin
                if (ct_tick) begin
                    count_nxt = divisor; // [RULE21]
                    out_nxt = 1'b1;
                    state_nxt = bit_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = bit_pkg::ST_IDLE;
            end
        endcase
        // received character stops the count until the next divider tick
        if (rx_load) begin
            state_nxt = bit_pkg::ST_RESTART; // [RULE21]
        end
        // entering time-out mode halts until the first character
        if (to_on) begin
            state_nxt = bit_pkg::ST_IDLE; // [RULE20]
            out_nxt = 1'b1;
        end
    end

    // falling output sets ready; set wins over any clear in the same cycle
    wire logic ready_set = out_r && !out_nxt; // [RULE3] [RULE8] [RULE11]
    wire logic ready_clr = stop_ok || to_on || restart_now; // [RULE6]
    wire logic ready_nxt = ready_set || (ready_r && !ready_clr);
    wire logic to_nxt = to_on ? 1'b1 : to_off ? 1'b0 : to_en_r; // [RULE20]
    wire logic ct_rise = out_nxt && !out_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= bit_pkg::ST_IDLE; // [RULE22]
            count_r <= bit_pkg::CNT_ZERO;
            out_r <= bit_pkg::CT_OUT_RST;
            ready_r <= bit_pkg::READY_RST;
            to_en_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            out_r <= out_nxt;
            ready_r <= ready_nxt;
            to_en_r <= to_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_d_r <= 1'b0;
            pre_r <= 4'h0;
            ext_t_d_r <= 4'h0;
            ever_r <= 1'b0;
        end else if (clk_en) begin
            ext_d_r <= ct_ext_clk;
            pre_r <= pre_r + 4'h1;
            ext_t_d_r <= ext_timing;
            ever_r <= ever_r || start_ok || rx_load;
        end
    end

    // per-selector source choice
    function automatic logic pick_tick(input logic [1:0] src, input logic rate_generator,
                                       input logic ct, input logic ext);
        unique case (bit_pkg::bit_baud_src_t'(src))
            bit_pkg::BS_CT: pick_tick = ct;
            bit_pkg::BS_EXT: pick_tick = ext;
            bit_pkg::BS_RATE, bit_pkg::BS_RSV: pick_tick = rate_generator;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < bit_pkg::N_SEL; g++) begin : g_sel
            wire logic ext_edge = ext_timing[g] && !ext_t_d_r[g];
            // divider period is one 16x tick when picked as baud clock
            wire logic pick = pick_tick(baud_src[g*bit_pkg::BSRC_W +: bit_pkg::BSRC_W],
                                        rif.brg_tick[g], ct_rise, ext_edge); // [RULE18] [RULE10]
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    tick_r[g] <= 1'b0;
                end else if (clk_en) begin
                    tick_r[g] <= pick;
                end
            end

            a_divider_tick: assert property (@(posedge clock) disable iff (rst) // [RULE10]
                clk_en && baud_src[g*bit_pkg::BSRC_W +: bit_pkg::BSRC_W] == bit_pkg::BS_CT
                && ct_rise |=> baud_tick[g])
                else $error("divider rise gave no baud tick");
        end
    endgenerate

    // pin idles high when the divider is not routed to it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_r <= 1'b1;
        end else if (clk_en) begin
            pin_r <= ct_route_en ? out_nxt : 1'b1; // [RULE19]
        end
    end

    assign baud_tick = tick_r;
    assign ct_out = out_r;
    assign ct_pin_out = pin_r;
    assign ready_flag = ready_r;
    // live count; not meaningful in timer mode
    assign count_value = count_r; // [RULE13] [RULE9]
    assign timeout_mode = to_en_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_start;
        clk_en && start_ok;
    endsequence

    sequence s_loaded;
        count_value == $past(divisor) && ct_out;
    endsequence

    sequence s_restart;
        clk_en && restart_now && !to_on;
    endsequence

    a_start_loads: assert property (s_start |=> s_loaded) // [RULE5]
        else $error("start did not load the divisor");

    a_ready_on_fall: assert property ($fell(ct_out) |-> ready_flag) // [RULE3]
        else $error("output fell without ready");

    a_stop_clears: assert property (clk_en && stop_ok && !ready_set |=> !ready_flag) // [RULE6]
        else $error("stop left ready set");

    a_idle_reset: assert property (!ever_r |-> ct_out && !ready_flag) // [RULE22]
        else $error("divider active before first start");

    a_counter_wrap: assert property (clk_en && state_r == bit_pkg::ST_RUN // [RULE12]
        && !timer_mode && ct_tick && at_zero && !start_ok && !stop_ok && !rx_load && !to_on
        |=> count_value == bit_pkg::CNT_WRAP && $stable(ct_out))
        else $error("counter did not wrap quietly");

    a_counter_zero: assert property (clk_en && state_r == bit_pkg::ST_RUN // [RULE11]
        && !timer_mode && ct_tick && at_one && !start_ok && !stop_ok && !rx_load && !to_on
        |=> count_value == bit_pkg::CNT_ZERO && !ct_out && ready_flag)
        else $error("zero reach missed flag or output");

    a_timer_half: assert property (clk_en && state_r == bit_pkg::ST_RUN // [RULE7]
        && timer_mode && ct_tick && at_one && !start_ok && !rx_load && !to_on
        |=> ct_out != $past(ct_out) && count_value == $past(divisor))
        else $error("timer half period wrong");

    a_timer_stop: assert property (clk_en && timer_mode && stop_cmd // [RULE8]
        && state_r == bit_pkg::ST_RUN && !rx_load && !to_on
        |=> state_r == bit_pkg::ST_RUN)
        else $error("stop halted timer mode");

    a_timeout_on: assert property (clk_en && to_on // [RULE20]
        |=> timeout_mode && ct_out && !ready_flag && state_r == bit_pkg::ST_IDLE)
        else $error("time-out enable misbehaved");

    a_timeout_restart: assert property (s_restart // [RULE21]
        |=> !ready_flag && ct_out && count_value == $past(divisor))
        else $error("time-out restart wrong");

    a_timeout_off: assert property (clk_en && to_off && !to_on // [RULE20]
        |=> !timeout_mode)
        else $error("time-out disable ignored");

    a_rx_hold: assert property (clk_en && rx_load && !to_on // [RULE21]
        |=> state_r == bit_pkg::ST_RESTART)
        else $error("received character did not halt the count");

    a_start_refused: assert property (clk_en && start_cmd && timeout_mode // [RULE4]
        && state_r == bit_pkg::ST_IDLE && !rx_load && !to_on
        |=> state_r == bit_pkg::ST_IDLE)
        else $error("start accepted in time-out mode");

    a_stop_idles: assert property (clk_en && stop_ok && !start_ok && !timer_mode // [RULE13]
        && state_r == bit_pkg::ST_RUN
        |=> state_r == bit_pkg::ST_IDLE && count_value == $past(count_value))
        else $error("stop did not freeze the counter");

    a_ready_sticky: assert property (clk_en && ready_flag && !stop_ok && !to_on // [RULE3]
        && !restart_now |=> ready_flag)
        else $error("ready dropped without a clear");

    a_ext_hold: assert property (clk_en && state_r == bit_pkg::ST_RUN // [RULE2]
        && ct_src == bit_pkg::CT_SRC_EXT && !ext_rise && !start_ok && !rx_load && !to_on
        |=> count_value == $past(count_value))
        else $error("count moved without an external edge");

    a_pin_follow: assert property (clk_en && ct_route_en |=> ct_pin_out == ct_out) // [RULE19]
        else $error("routed pin lags the divider output");

    a_pin_release: assert property (clk_en && !ct_route_en |=> ct_pin_out) // [RULE19]
        else $error("unrouted pin not high");
endmodule
`default_nettype wire

// ---- dv/bit_timer_tb_top.sv ----
// Purpose: self-checking bench for the baud and interval timer
// Assumes: inputs change on the falling edge; outputs are sampled there too
// Notes: one falling edge after a command shows its registered effect
`timescale 1ns/10ps
`default_nettype none
module bit_timer_tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] div_lo = 8'h00;
    logic [7:0] div_hi = 8'h00;
    logic [2:0] mode_sel = 3'h1;
    logic ext_clk = 1'b0;
    logic start_cmd = 1'b0;
    logic stop_cmd = 1'b0;
    logic a_wr = 1'b0;
    logic [3:0] a_cmd = 4'h0;
    logic b_wr = 1'b0;
    logic [3:0] b_cmd = 4'h0;
    logic load_a = 1'b0;
    logic load_b = 1'b0;
    logic ext_rates = 1'b0;
    logic [19:0] rate_idx = 20'h00000;
    logic [7:0] baud_src = 8'h00;
    logic [3:0] ext_timing = 4'h0;
    logic route_en = 1'b0;
    logic [3:0] baud_tick;
    logic ct_out;
    logic ct_pin_out;
    logic ready_flag;
    logic [15:0] count_value;
    logic timeout_mode;
    int err_total = 0;
    int checks_done = 0;
    int n;
    int tk [4];

    always #25 clock = ~clock;

    bit_timer uut (
        .clock(clock), .rst(rst), .clk_en(clk_en),
        .divisor_low_byte(div_lo), .divisor_high_byte(div_hi),
        .ct_mode_sel(mode_sel), .ct_ext_clk(ext_clk),
        .start_cmd(start_cmd), .stop_cmd(stop_cmd),
        .channel_a_cmd_wr(a_wr), .channel_a_cmd(a_cmd),
        .channel_b_cmd_wr(b_wr), .channel_b_cmd(b_cmd),
        .rx_fifo_load_a(load_a), .rx_fifo_load_b(load_b),
        .ext_rates_en(ext_rates), .rate_index(rate_idx), .baud_src(baud_src),
        .ext_timing(ext_timing), .ct_route_en(route_en), .baud_tick(baud_tick),
        .ct_out(ct_out), .ct_pin_out(ct_pin_out), .ready_flag(ready_flag),
        .count_value(count_value), .timeout_mode(timeout_mode)
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask

    task automatic st(input logic [15:0] c, input logic o, input logic r);
        check(count_value, c, "count");
        check({15'h0000, ct_out}, {15'h0000, o}, "divider output");
        check({15'h0000, ready_flag}, {15'h0000, r}, "ready flag");
    endtask

    task automatic go(input logic [15:0] d, input logic [2:0] m);
        {div_hi, div_lo} = d;
        mode_sel = m;
        start_cmd = 1'b1;
        cyc(1);
        start_cmd = 1'b0;
    endtask

    task automatic stop();
        stop_cmd = 1'b1;
        cyc(1);
        stop_cmd = 1'b0;
    endtask

    // counter mode, idle, ready clear, then a clean start
    task automatic fresh(input logic [15:0] d, input logic [2:0] m);
        go(d, 3'h1);
        stop();
        go(d, m);
    endtask

    task automatic cmd(input logic b, input logic [3:0] code);
        {a_cmd, b_cmd} = {code, code};
        a_wr = !b;
        b_wr = b;
        cyc(1);
        {a_wr, b_wr} = 2'b00;
    endtask

    // bounded wait for the ready flag; running out ends the run
    task automatic wait_ready(input int lim, output int k);
        k = 0;
        while (ready_flag !== 1'b1 && k < lim) begin
            cyc(1);
            k++;
        end
        if (ready_flag !== 1'b1) begin
            check(16'h0000, 16'h0001, "ready wait ran out");
            end_of_test();
        end
    endtask

    // counts 16x ticks per selector; ext_timing[1] rises on every second cycle for the first 2*rises cycles
    task automatic window(input int len, input int rises);
        tk = '{0, 0, 0, 0};
        for (int i = 0; i < len; i++) begin
            if (i < 2 * rises) ext_timing[1] = ~ext_timing[1];
            cyc(1);
            for (int g = 0; g < 4; g++) tk[g] += int'(baud_tick[g]);
        end
    endtask

    initial begin
        cyc(2);
        rst = 1'b0;
        cyc(1);
        st(16'h0000, 1'b1, 1'b0);
        check({12'h000, baud_tick}, 16'h0000, "idle ticks");
        $display("test reset done");

        go(16'h0100, 3'h1);
        cyc(2);
        go(16'h0002, 3'h1);
        st(16'h0002, 1'b1, 1'b0);
        cyc(1);
        st(16'h0001, 1'b1, 1'b0);
        cyc(1);
        st(16'h0000, 1'b0, 1'b1);
        cyc(1);
        st(16'hFF55, 1'b0, 1'b1);
        cyc(1);
        st(16'hFF54, 1'b0, 1'b1);
        clk_en = 1'b0;
        cyc(3);
        st(16'hFF54, 1'b0, 1'b1);
        clk_en = 1'b1;
        stop();
        n = int'(count_value);
        check({15'h0000, ready_flag}, 16'h0000, "ready after stop");
        cyc(3);
        check(count_value, 16'(n), "count held after stop");
        $display("test counter done");

        route_en = 1'b1;
        go(16'h0002, 3'h5);
        for (int i = 0; i < 7; i++) begin
            st((i % 2 == 0) ? 16'h0002 : 16'h0001, !((i >> 1) & 1), i >= 2);
            check({15'h0000, ct_pin_out}, {15'h0000, (i % 4) < 2}, "pin follows");
            cyc(1);
        end
        stop();
        check({15'h0000, ready_flag}, 16'h0000, "ready after stop");
        wait_ready(8, n);
        check({15'h0000, ready_flag}, 16'h0001, "timer runs on");
        route_en = 1'b0;
        cyc(2);
        check({15'h0000, ct_pin_out}, 16'h0001, "pin released");
        $display("test timer done");

        fresh(16'h0003, 3'h1);
        wait_ready(10, n);
        check(16'(n), 16'h0003, "osc source");
        fresh(16'h0003, 3'h3);
        wait_ready(10, n);
        check(16'(n), 16'h0003, "alternate osc source");
        fresh(16'h0003, 3'h2);
        wait_ready(50, n);
        check(16'(n >= 33 && n <= 48), 16'h0001, "prescaled source");
        fresh(16'h0001, 3'h0);
        cyc(3);
        st(16'h0001, 1'b1, 1'b0);
        ext_clk = 1'b1;
        wait_ready(3, n);
        check(count_value, 16'h0000, "external source");
        ext_clk = 1'b0;
        $display("test sources done");

        cmd(1'b0, bit_pkg::CMD_TO_ON);
        check({15'h0000, timeout_mode}, 16'h0001, "time-out on");
        check({14'h0000, ct_out, ready_flag}, 16'h0002, "time-out idle");
        go(16'h0002, 3'h1);
        cyc(6);
        check({14'h0000, ct_out, ready_flag}, 16'h0002, "start refused");
        load_a = 1'b1;
        cyc(1);
        load_a = 1'b0;
        cyc(1);
        st(16'h0002, 1'b1, 1'b0);
        cyc(2);
        st(16'h0000, 1'b0, 1'b1);
        stop();
        check({15'h0000, ready_flag}, 16'h0001, "stop refused");
        load_b = 1'b1;
        cyc(1);
        load_b = 1'b0;
        cyc(1);
        st(16'h0002, 1'b1, 1'b0);
        cmd(1'b0, 4'h3);
        check({15'h0000, timeout_mode}, 16'h0001, "other code ignored");
        cyc(1);
        cmd(1'b1, bit_pkg::CMD_TO_OFF);
        check({15'h0000, timeout_mode}, 16'h0000, "time-out off");
        $display("test time-out done");

        go(16'h0001, 3'h5);
        baud_src = 8'h09;
        rate_idx = {5'h1C, 5'h1B, 10'h000};
        cyc(20);
        window(60, 20);
        check(16'(tk[0]), 16'h001E, "divider ticks");
        check(16'(tk[1]), 16'h0014, "external ticks");
        check(16'(tk[2]), 16'(60 / bit_pkg::RATE_DIV[27]), "rate ticks");
        check(16'(tk[3]), 16'h0000, "extended rate off");
        ext_rates = 1'b1;
        rate_idx = {5'h1E, 5'h1C, 10'h000};
        cyc(20);
        window(60, 0);
        check(16'(tk[2]), 16'(60 / bit_pkg::RATE_DIV[28]), "extended rate");
        check(16'(tk[3]), 16'(60 / bit_pkg::RATE_DIV[30]), "fastest rate");
        $display("test baud ticks done");

        rst = 1'b1;
        cyc(1);
        st(16'h0000, 1'b1, 1'b0);
        check({15'h0000, timeout_mode}, 16'h0000, "mode after reset");
        rst = 1'b0;
        cyc(2);
        st(16'h0000, 1'b1, 1'b0);
        $display("test second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
